// *** src/usb_epctl_pkg.sv ***
// constants and types for the endpoint control and status block
////////////////////////////////////////////////////////////////////////////////
package usb_epctl_pkg;
  localparam int unsigned STAT_DEPTH = 4;
  localparam int unsigned NUM_EP = 16;
  // register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h00C;
  localparam logic [11:0] OFS_MODE = 12'h010;
  localparam logic [11:0] OFS_EP_BASE = 12'h040;
  localparam logic [11:0] OFS_EP_LAST = 12'h07C;
  // status fields
  localparam int unsigned STAT_EP_LSB = 4;
  localparam int unsigned STAT_DIR_BIT = 3;
  localparam int unsigned STAT_BANK_BIT = 2;
  // endpoint control fields
  localparam int unsigned EP_LOW_SPEED_DIRECT_ENABLE_BIT = 7;
  localparam int unsigned EP_NORETRY_BIT = 6;
  localparam int unsigned EP_CONDIS_BIT = 4;
  localparam int unsigned EP_RXEN_BIT = 3;
  localparam int unsigned EP_TXEN_BIT = 2;
  localparam int unsigned EP_STALL_BIT = 1;
  localparam int unsigned EP_HSHK_BIT = 0;
  localparam logic [7:0] EP_WRITE_MASK = 8'hDF;
  localparam logic [7:0] EP_RESET = 8'h00;
  // interrupt bits
  localparam int unsigned IRQ_TRN_BIT = 0;
  localparam int unsigned IRQ_STALL_BIT = 1;
  localparam int unsigned IRQ_NAK_BIT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam int unsigned MODE_HOST_BIT = 0;
  typedef enum logic [1:0] {
    PID_OUT = 2'h0,
    PID_IN = 2'h1,
    PID_SETUP = 2'h2
  } token_kind_t;
  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_WAIT = 3'b010,
    APB_DONE = 3'b100
  } apb_state_t;
endpackage

// *** src/usb_status_queue.sv ***
// queue of completed transfer records, head visible to software
module usb_status_queue
  import usb_epctl_pkg::*;
#(
  parameter int unsigned WIDTH = 6,
  parameter int unsigned DEPTH = STAT_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic empty_o,
  output logic full_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0] count;
  logic do_pop;
  logic do_push;

  assign do_pop = pop_i && (count != '0);
  // a full queue drops the new record unless a pop in the same cycle frees a slot; the link is warned by full_o
  assign do_push = push_i && ((count != (AW+1)'(DEPTH)) || do_pop);
  assign head_o = mem[rd_ptr];
  assign empty_o = (count == '0);
  assign full_o = (count == (AW+1)'(DEPTH));

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// *** src/usb_token_check.sv ***
// decides how an endpoint answers a token from its control byte
module usb_token_check
  import usb_epctl_pkg::*;
(
  input wire logic [7:0] ctrl_i,
  input wire logic [1:0] kind_i,
  output logic accept_o,
  output logic stall_o,
  output logic handshake_o
);
  logic rx_en;
  logic tx_en;
  logic setup_ok;

  assign rx_en = ctrl_i[EP_RXEN_BIT];
  assign tx_en = ctrl_i[EP_TXEN_BIT];
  // bit 4 only counts on a bidirectional endpoint
  assign setup_ok = rx_en && !(tx_en && ctrl_i[EP_CONDIS_BIT]);

  always_comb begin
    accept_o = 1'b0;
    case (kind_i)
      PID_OUT: accept_o = rx_en;
      PID_IN: accept_o = tx_en;
      PID_SETUP: accept_o = setup_ok;
      default: accept_o = 1'b0;
    endcase
  end

  assign stall_o = ctrl_i[EP_STALL_BIT];
  assign handshake_o = ctrl_i[EP_HSHK_BIT];
endmodule

// *** src/usb_epctl.sv ***
// endpoint control registers and transaction status queue with APB access
module usb_epctl
  import usb_epctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // completed transfers from the USB engine
  input wire logic xfer_done_i,
  input wire logic [3:0] xfer_ep_i,
  input wire logic xfer_tx_i,
  input wire logic xfer_odd_i,
  output logic xfer_room_o,
  // token lookup from the USB engine
  input wire logic tok_valid_i,
  input wire logic [3:0] tok_ep_i,
  input wire logic [1:0] tok_kind_i,
  output logic tok_reply_valid_o,
  output logic tok_accept_o,
  output logic tok_stall_o,
  output logic tok_handshake_o,
  // endpoint stall and host NAK events
  input wire logic stall_event_i,
  input wire logic [3:0] stall_ep_i,
  input wire logic nak_rcvd_i,
  output logic nak_retry_o,
  // host mode from the mode register, low-speed setting from endpoint 0, and the interrupt
  output logic host_mode_o,
  output logic low_speed_direct_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] ep_ctrl [NUM_EP];
  logic host_mode;
  logic stall_sticky;
  logic nak_sticky;
  logic [IRQ_W-1:0] irq_clear;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_flags;
  apb_state_t apb_state;
  apb_state_t next_apb_state;
  logic wr_take;
  logic rd_take;
  logic [31:0] next_rdata;
  logic next_err;
  logic [5:0] q_head;
  logic q_empty;
  logic q_full;
  logic q_pop;
  logic trn_flag;
  logic chk_accept;
  logic chk_stall;
  logic chk_hshk;
  logic [31:0] wmask;
  logic [3:0] sel_ep;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic is_ep_addr(input logic [11:0] a);
    return (a >= OFS_EP_BASE) && (a <= OFS_EP_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] ep_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFS_EP_BASE;
    return d[5:2];
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: two wait states, answer registered
  // idle sees the access phase, wait raises pready, done lets it fall;
  // registering the answer costs a cycle but keeps every output on a flop
  always_comb begin
    next_apb_state = apb_state;
    case (apb_state)
      APB_IDLE: begin
        if (psel_i && penable_i) begin
          next_apb_state = APB_WAIT;
        end
      end
      APB_WAIT: next_apb_state = APB_DONE;
      APB_DONE: next_apb_state = APB_IDLE;
      default: next_apb_state = APB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      apb_state <= APB_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  // pready stands on the third access edge; writes land on that edge,
  // the one at which the master sees pready, never a cycle early
  assign wr_take = pready_o && psel_i && penable_i && pwrite_i;
  assign rd_take = (apb_state == APB_WAIT) && psel_i && penable_i && !pwrite_i;
  assign wmask = pwdata_i & byte_mask(pstrb_i);
  assign sel_ep = ep_index(paddr_i);

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (is_ep_addr(paddr_i)) begin
      next_rdata = {24'h00_0000, ep_ctrl[sel_ep]};
    end else begin
      case (paddr_i)
        // head of the queue; undefined while the flag is low
        OFS_STATUS: next_rdata = {24'h00_0000, q_head, 2'h0};
        OFS_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_flags};
        OFS_IRQ_ENABLE: next_rdata = {29'h0000_0000, irq_enable};
        OFS_IRQ_CLEAR: next_rdata = 32'h0000_0000;
        OFS_MODE: next_rdata = {31'h0000_0000, host_mode};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= (apb_state == APB_WAIT) && psel_i && penable_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= (apb_state == APB_WAIT) && psel_i && penable_i && next_err;
    end
  end

  // read data holds until the next read, so a slow master still finds it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      prdata_o <= next_err ? 32'h0000_0000 : next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and interrupt enable registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_mode <= 1'b0;
    end else if (wr_take && (paddr_i == OFS_MODE)) begin
      host_mode <= wmask[MODE_HOST_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_enable <= IRQ_RESET;
    end else if (wr_take && (paddr_i == OFS_IRQ_ENABLE)) begin
      irq_enable <= wmask[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoint control registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_ctrl[i] <= EP_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (wr_take && is_ep_addr(paddr_i) && (sel_ep == 4'(i))) begin
          // bit 5 is not stored and stays zero
          ep_ctrl[i] <= (ep_ctrl[i] & ~(EP_WRITE_MASK & {8{pstrb_i[0]}}))
                        | (wmask[7:0] & EP_WRITE_MASK);
        end
        // a stall from the engine wins over a software write
        if (stall_event_i && (stall_ep_i == 4'(i))) begin
          ep_ctrl[i][EP_STALL_BIT] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction status queue
  // writing 1 to the complete flag in the clear register pops one record
  assign q_pop = wr_take && (paddr_i == OFS_IRQ_CLEAR) && wmask[IRQ_TRN_BIT];

  usb_status_queue #(
    .WIDTH(6),
    .DEPTH(STAT_DEPTH)
  ) u_queue (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_i(xfer_done_i),
    .data_i({xfer_ep_i, xfer_tx_i, xfer_odd_i}),
    .pop_i(q_pop),
    .head_o(q_head),
    .empty_o(q_empty),
    .full_o(q_full)
  );

  // flag stays up while any record waits, so a push during a pop keeps it up
  assign trn_flag = !q_empty;

  // one cycle late: the engine must not count on room in the pushing cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_room_o <= 1'b1;
    end else begin
      xfer_room_o <= !q_full;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events; hardware set wins over a clear in the same cycle
  assign irq_clear = (wr_take && (paddr_i == OFS_IRQ_CLEAR)) ? wmask[IRQ_W-1:0] : IRQ_RESET;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stall_sticky <= 1'b0;
    end else if (stall_event_i) begin
      stall_sticky <= 1'b1;
    end else if (irq_clear[IRQ_STALL_BIT]) begin
      stall_sticky <= 1'b0;
    end
  end

  // a NAK only counts while acting as host
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nak_sticky <= 1'b0;
    end else if (nak_rcvd_i && host_mode) begin
      nak_sticky <= 1'b1;
    end else if (irq_clear[IRQ_NAK_BIT]) begin
      nak_sticky <= 1'b0;
    end
  end

  // the complete flag is the queue state itself, not a stored bit
  assign irq_flags = {nak_sticky, stall_sticky, trn_flag};

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_flags & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // token replies, one cycle after the lookup
  usb_token_check u_check (
    .ctrl_i(ep_ctrl[tok_ep_i]),
    .kind_i(tok_kind_i),
    .accept_o(chk_accept),
    .stall_o(chk_stall),
    .handshake_o(chk_hshk)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tok_reply_valid_o <= 1'b0;
    end else begin
      tok_reply_valid_o <= tok_valid_i;
    end
  end

  // a stalled endpoint never accepts, whatever its enables say
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tok_accept_o <= 1'b0;
    end else begin
      tok_accept_o <= tok_valid_i && chk_accept && !chk_stall;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tok_stall_o <= 1'b0;
    end else begin
      tok_stall_o <= tok_valid_i && chk_stall;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tok_handshake_o <= 1'b0;
    end else begin
      tok_handshake_o <= tok_valid_i && chk_hshk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host-mode options: only endpoint 0 and only in host mode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_mode_o <= 1'b0;
    end else begin
      host_mode_o <= host_mode;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_speed_direct_o <= 1'b0;
    end else begin
      // clear means low-speed traffic goes through a hub with a preamble
      low_speed_direct_o <= host_mode && ep_ctrl[0][EP_LOW_SPEED_DIRECT_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nak_retry_o <= 1'b0;
    end else begin
      // retry pulse asks the engine to resend the NAKed transaction
      nak_retry_o <= host_mode && nak_rcvd_i
                     && !ep_ctrl[0][EP_NORETRY_BIT];
    end
  end
endmodule

// *** verif/usb_engine_model.sv ***
// behavioural USB engine: completed transfers, tokens and bus events
module usb_engine_model (
  input wire logic clk_i,
  output logic xfer_done_o = 1'h0,
  output logic [3:0] xfer_ep_o = 4'h0,
  output logic xfer_tx_o = 1'h0,
  output logic xfer_odd_o = 1'h0,
  output logic tok_valid_o = 1'h0,
  output logic [3:0] tok_ep_o = 4'h0,
  output logic [1:0] tok_kind_o = 2'h0,
  output logic stall_o = 1'h0,
  output logic [3:0] stall_ep_o = 4'h0,
  output logic nak_o = 1'h0
);
  ////////////////////////////////////////////////////////////
  // released fields turn to their inverse so stale values never pass
  task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
    @(posedge clk_i);
    xfer_done_o <= 1'h1;
    {xfer_ep_o, xfer_tx_o, xfer_odd_o} <= {ep, tx, odd};
    @(posedge clk_i);
    xfer_done_o <= 1'h0;
    {xfer_ep_o, xfer_tx_o, xfer_odd_o} <= ~{ep, tx, odd};
  endtask
  task automatic tok(input logic [3:0] ep, input logic [1:0] kind);
    @(posedge clk_i);
    {tok_valid_o, tok_ep_o, tok_kind_o} <= {1'h1, ep, kind};
    @(posedge clk_i);
    {tok_valid_o, tok_ep_o, tok_kind_o} <= {1'h0, ~ep, ~kind};
  endtask
  task automatic ev(input logic stall, input logic [3:0] ep);
    @(posedge clk_i);
    {stall_o, nak_o, stall_ep_o} <= {stall, !stall, ep};
    @(posedge clk_i);
    {stall_o, nak_o, stall_ep_o} <= {2'h0, ~ep};
  endtask
endmodule

// *** verif/usb_epctl_properties.sv ***
// assertions on the endpoint control block ports
module usb_epctl_checker
  import usb_epctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tok_valid_i,
  input wire logic [3:0] tok_ep_i,
  input wire logic [1:0] tok_kind_i,
  input wire logic tok_reply_valid_o,
  input wire logic tok_accept_o,
  input wire logic tok_stall_o,
  input wire logic stall_event_i,
  input wire logic [3:0] stall_ep_i,
  input wire logic nak_rcvd_i,
  input wire logic nak_retry_o,
  input wire logic host_mode_o,
  input wire logic low_speed_direct_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] ctl [16];
  logic [7:0] c;
  logic ep_wr;
  assign c = ctl[tok_ep_i];
  assign ep_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i[11:6] == 6'h01
                 && paddr_i[1:0] == 2'h0;
  ////////////////////////////////////////////////////////////
  // shadow of the control bytes; a stall event wins over a write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl <= '{default: 8'h00};
    end else begin
      if (ep_wr) begin
        ctl[paddr_i[5:2]] <= pwdata_i[7:0] & EP_WRITE_MASK;
      end
      if (stall_event_i) begin
        ctl[stall_ep_i][1] <= 1'h1;
      end
    end
  end
  sequence s_access;
    psel_i && !penable_i ##1 psel_i && penable_i;
  endsequence
  a_apb_answer: assert property (s_access |=> ##1 pready_o)
    else $error("no ready after access phase");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_decode: assert property (pready_o |-> pslverr_o ==
    !(paddr_i[1:0] == 2'h0 && (paddr_i <= OFS_MODE || paddr_i[11:6] == 6'h01)))
    else $error("error response wrong for address");
  a_read_top_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_ep_readback: assert property (pready_o && !pwrite_i && paddr_i[11:6] == 6'h01
    |-> prdata_o[7:0] == ctl[paddr_i[5:2]])
    else $error("control readback wrong");
  a_token_accept: assert property (tok_valid_i |=> tok_reply_valid_o &&
    tok_accept_o == $past(!c[1] && (tok_kind_i == 2'h0 ? c[3] :
    tok_kind_i == 2'h1 ? c[2] : c[3] && !(c[2] && c[4]))))
    else $error("token acceptance wrong");
  a_token_stall: assert property (tok_valid_i |=> tok_stall_o == $past(c[1]))
    else $error("token stall reply wrong");
  a_nak_retry: assert property (nak_rcvd_i |=>
    nak_retry_o == $past(host_mode_o && !ctl[0][6]))
    else $error("retry decision wrong");
  a_low_speed: assert property (low_speed_direct_o == (host_mode_o && $past(ctl[0][7])))
    else $error("low speed output wrong");
endmodule
bind usb_epctl usb_epctl_checker chk (
  .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .tok_valid_i, .tok_ep_i, .tok_kind_i, .tok_reply_valid_o, .tok_accept_o,
  .tok_stall_o, .stall_event_i, .stall_ep_i, .nak_rcvd_i, .nak_retry_o, .host_mode_o,
  .low_speed_direct_o
);

// *** verif/usb_epctl_tb_top.sv ***
// self-checking bench for the endpoint control and status block
module usb_epctl_tb_top
  import usb_epctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] ep;
    logic [7:0] ctl;
    logic [1:0] kind;
    logic [2:0] exp;
  } row_t;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, xfer_done_i, xfer_tx_i, xfer_odd_i, xfer_room_o;
  logic [3:0] xfer_ep_i, tok_ep_i, stall_ep_i, tk;
  logic [1:0] tok_kind_i;
  logic tok_valid_i, tok_reply_valid_o, tok_accept_o, tok_stall_o, tok_handshake_o;
  logic stall_event_i, nak_rcvd_i, nak_retry_o, host_mode_o, low_speed_direct_o, irq_o;
  int miscompares = 0;
  int comparisons = 0;
  // {endpoint, transmit, odd}; the fifth finds the queue full
  logic [5:0] q [5] = '{6'h0E, 6'h3D, 6'h03, 6'h28, 6'h17};
  // exp is {accept, stall, handshake}
  row_t rows [10] = '{
    '{4'h1, 8'h08, 2'h0, 3'h4}, '{4'h2, 8'h08, 2'h1, 3'h0}, '{4'h3, 8'h04, 2'h1, 3'h4},
    '{4'h4, 8'h04, 2'h0, 3'h0}, '{4'h5, 8'h1C, 2'h2, 3'h0}, '{4'h6, 8'h0C, 2'h2, 3'h4},
    '{4'h7, 8'h18, 2'h2, 3'h4}, '{4'h8, 8'h0D, 2'h0, 3'h5}, '{4'h9, 8'h0A, 2'h0, 3'h2},
    '{4'hF, 8'h0C, 2'h1, 3'h4}};
  usb_epctl uut (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'hF),
    .prdata_o, .pready_o, .pslverr_o, .xfer_done_i, .xfer_ep_i, .xfer_tx_i, .xfer_odd_i,
    .xfer_room_o, .tok_valid_i, .tok_ep_i, .tok_kind_i, .tok_reply_valid_o, .tok_accept_o,
    .tok_stall_o, .tok_handshake_o, .stall_event_i, .stall_ep_i, .nak_rcvd_i, .nak_retry_o,
    .host_mode_o, .low_speed_direct_o, .irq_o);
  usb_engine_model eng (
    .clk_i, .xfer_done_o(xfer_done_i), .xfer_ep_o(xfer_ep_i), .xfer_tx_o(xfer_tx_i),
    .xfer_odd_o(xfer_odd_i), .tok_valid_o(tok_valid_i), .tok_ep_o(tok_ep_i),
    .tok_kind_o(tok_kind_i), .stall_o(stall_event_i), .stall_ep_o(stall_ep_i), .nak_o(nak_rcvd_i));
  ////////////////////////////////////////////////////////////
  always #12.5 clk_i = ~clk_i;
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, seen);
    end
  endtask
  // waits on pready only; the watchdog catches a hung slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, wr, a, d};
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'h1);
    rd = prdata_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [11:0] ea(input logic [3:0] ep);
    return OFS_EP_BASE + {6'h00, ep, 2'h0};
  endfunction
  task automatic rdchk(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(w, rd, e);
  endtask
  task automatic hostchk(input logic [2:0] e);
    eng.ev(1'h0, 4'h0);
    #1;
    check("host", {29'h0, host_mode_o, low_speed_direct_o, nak_retry_o}, {29'h0, e});
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'h1;
    foreach (rows[i]) begin
      rdchk("ctl reset", ea(rows[i].ep), 32'h0);
      apb(1'h1, ea(rows[i].ep), {24'hFFFFFF, rows[i].ctl | 8'h20});
      rdchk("ctl readback", ea(rows[i].ep), {24'h0, rows[i].ctl});
      eng.tok(rows[i].ep, rows[i].kind);
      #1;
      tk = {tok_reply_valid_o, tok_accept_o, tok_stall_o, tok_handshake_o};
      check("token", {28'h0, tk}, {28'h0, 1'h1, rows[i].exp});
    end
    eng.xfer(q[0][5:2], q[0][1], q[0][0]);
    tick(2);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    apb(1'h1, OFS_IRQ_ENABLE, 32'h7);
    tick(2);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    for (int i = 1; i < 5; i++) eng.xfer(q[i][5:2], q[i][1], q[i][0]);
    tick(1);
    check("room", {31'h0, xfer_room_o}, 32'h0);
    apb(1'h1, OFS_STATUS, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      rdchk("flag", OFS_IRQ_STATUS, 32'h1);
      rdchk("status", OFS_STATUS, {24'h0, q[i], 2'h0});
      apb(1'h1, OFS_IRQ_CLEAR, 32'h1);
    end
    rdchk("flag empty", OFS_IRQ_STATUS, 32'h0);
    tick(2);
    check("irq idle", {30'h0, irq_o, xfer_room_o}, 32'h1);
    eng.ev(1'h1, 4'h2);
    rdchk("stall flag", OFS_IRQ_STATUS, 32'h2);
    rdchk("stall bit", ea(4'h2), 32'h0A);
    apb(1'h1, OFS_IRQ_CLEAR, 32'h2);
    rdchk("stall cleared", OFS_IRQ_STATUS, 32'h0);
    rdchk("unmapped", 12'h020, 32'h0);
    apb(1'h1, OFS_MODE, 32'h1);
    apb(1'h1, ea(4'h1), 32'hC8);
    apb(1'h1, ea(4'h0), 32'h40);
    hostchk(3'h4);
    apb(1'h1, ea(4'h0), 32'h80);
    hostchk(3'h7);
    rdchk("nak flag", OFS_IRQ_STATUS, 32'h4);
    apb(1'h1, OFS_MODE, 32'h0);
    hostchk(3'h0);
    eng.xfer(4'h1, 1'h1, 1'h1);
    rst_b_i <= 1'h0;
    tick(2);
    check("reset outputs", {30'h0, irq_o, xfer_room_o}, 32'h1);
    @(posedge clk_i);
    rst_b_i <= 1'h1;
    rdchk("ctl after reset", ea(4'h1), 32'h0);
    rdchk("flag after reset", OFS_IRQ_STATUS, 32'h0);
    conclude();
  end
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
endmodule
